/* File: hw/dfs_top.sv */
// Drive fault supervisor: monitor select, speed trip, auto reset, loop check
//
// How it works
// - Monitor 1 selector 0..8, default 3
// - Monitor outputs saturate at plus/minus 10 V
// - Per-channel multiplier, default 0.80
// - Sustained speed error trips drive, fault F410
// - Threshold 0..100 percent, strictly greater compare
// - Auto reset clears shutdown fault itself
// - Auto reset attempt 5 s after fault
// - Auto reset enable bit, default off
// - Count 5 raises fault 411, manual reset
// - Contactor feedback mismatch flags loop fault
// - Loop window 450 ms or 3 s
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`include "dfs_cfg.svh"
module dfs_top
    import dfs_pkg::*;
#(
    parameter int TICK_CYC = `DFS_TICK_CYC,  // Cycles per 10 ms tick
    parameter int LEAK_TK  = `DFS_LEAK_TK    // Ticks per count decrement
) (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Internal quantities, per unit 1.0 = 4096
    input  wire logic [15:0] back_emf_estimate,
    input  wire logic [15:0] speed_cmd_raw,
    input  wire logic [15:0] speed_cmd_ramped,
    input  wire logic [15:0] encoder_speed,
    input  wire logic [15:0] arm_cur_ref,
    input  wire logic [15:0] arm_cur_meas,
    input  wire logic [15:0] arm_volt_meas,
    input  wire logic [15:0] fld_cur_ref,
    input  wire logic [15:0] fld_cur_meas,
    input  wire logic [15:0] mon0_value,
    // Other drive faults causing shutdown
    input  wire logic        ext_fault,
    // Contactor
    input  wire logic        coil_cmd,
    input  wire logic        contactor_ack,
    // Outputs
    output logic      [15:0] mon0_volts,
    output logic      [15:0] mon1_volts,
    output logic             drive_shutdown,
    output logic      [11:0] fault_code,
    output logic             loop_fault
);
    // Settings
    logic        auto_rst_r;      // Auto reset enable
    logic        loop_3s_r;       // Long contactor window
    logic [3:0]  sel1_r;          // Monitor 1 source
    logic [15:0] mult0_r;         // Channel 0 multiplier
    logic [15:0] mult1_r;         // Channel 1 multiplier
    logic [15:0] trip_r;          // Trip time, 10 ms units
    logic [15:0] thr_r;           // Threshold, 0.1 percent units
    // State
    dfs_state_type state_r;
    dfs_state_type state_nxt;
    logic [23:0] tick_cnt_r;      // Cycle divider
    logic        tick;            // 10 ms pulse
    logic [23:0] leak_cnt_r;      // Decrement timer
    logic [2:0]  fcount_r;        // Accumulated faults
    logic [15:0] err_cnt_r;       // Error duration in ticks
    logic [9:0]  wait_r;          // Ticks since fault
    logic [1:0]  ack_sync_r;      // Feedback synchroniser
    logic [1:0]  fault_sync_r;    // Fault input synchroniser
    logic        fault_prev_r;    // Fault edge memory
    logic        speed_fault_r;   // Speed trip latched
    logic        manual_rst;      // Software reset strobe
    // Monitor carriers
    dfs_mon_if m0 ();
    dfs_mon_if m1 ();

    // APB decode
    logic wr_en;
    logic rd_en;
    logic hit;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign hit   = (paddr == `DFS_CTRL_ADDR) || (paddr == `DFS_MON_ADDR) ||
                   (paddr == `DFS_SPD_ADDR)  || (paddr == `DFS_STAT_ADDR) ||
                   (paddr == `DFS_CMD_ADDR);
    assign pready     = 1'b1;       // Zero wait states
    assign pslverr    = psel && penable && !hit;
    assign manual_rst = wr_en && (paddr == `DFS_CMD_ADDR) && pwdata[0];

    // Clamp a field to its documented range
    function automatic logic [15:0] clamp16(input logic [15:0] v,
                                            input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Register writes; out-of-range values are clamped, not refused
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            auto_rst_r <= 1'b0;
            loop_3s_r  <= 1'b0;
            sel1_r     <= `DFS_SEL1_RST;
            mult0_r    <= `DFS_MULT_RST;
            mult1_r    <= `DFS_MULT_RST;
            trip_r     <= `DFS_TRIP_RST;
            thr_r      <= `DFS_THR_RST;
        end else if (wr_en) begin
            if (paddr == `DFS_CTRL_ADDR) begin
                auto_rst_r <= pwdata[`DFS_AUTO_RST_BIT];
                loop_3s_r  <= pwdata[`DFS_LOOP_3S_BIT];
                sel1_r     <= (pwdata[3+4:4] > `DFS_SEL_MAX) ?
                              `DFS_SEL_MAX : pwdata[7:4];
            end else if (paddr == `DFS_MON_ADDR) begin
                mult0_r <= pwdata[15:0];
                mult1_r <= pwdata[31:16];
            end else if (paddr == `DFS_SPD_ADDR) begin
                trip_r <= clamp16(pwdata[15:0], `DFS_TRIP_MIN,
                                  `DFS_TRIP_MAX);
                thr_r  <= clamp16(pwdata[31:16], 16'h0000,
                                  `DFS_THR_MAX);
            end
        end
    end

    // Read mux, registered data
    logic [31:0] rd_mux;
    assign rd_mux =
        (paddr == `DFS_CTRL_ADDR) ? {24'h0, sel1_r, 2'b00, loop_3s_r,
                                     auto_rst_r} :
        (paddr == `DFS_MON_ADDR)  ? {mult1_r, mult0_r} :
        (paddr == `DFS_SPD_ADDR)  ? {thr_r, trip_r} :
        (paddr == `DFS_STAT_ADDR) ? {13'h0, fcount_r, fault_code,
                                     2'b00, loop_fault, drive_shutdown} :
        32'h0;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux; // Latched in setup, valid in access
        end
    end

    // Slow time base and free-running decrement timer
    assign tick = (tick_cnt_r == 24'(TICK_CYC - 1));
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_cnt_r <= 24'h0;
            leak_cnt_r <= 24'h0;
        end else begin
            tick_cnt_r <= tick ? 24'h0 : tick_cnt_r + 24'h1;
            if (tick) begin
                leak_cnt_r <= (leak_cnt_r == 24'(LEAK_TK - 1)) ?
                              24'h0 : leak_cnt_r + 24'h1;
            end
        end
    end
    logic leak;
    assign leak = tick && (leak_cnt_r == 24'(LEAK_TK - 1));

    // Input synchronisers
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ack_sync_r   <= 2'b00;
            fault_sync_r <= 2'b00;
            fault_prev_r <= 1'b0;
        end else begin
            ack_sync_r   <= {ack_sync_r[0], contactor_ack};
            fault_sync_r <= {fault_sync_r[0], ext_fault};
            fault_prev_r <= fault_sync_r[1];
        end
    end

    // Speed error magnitude against threshold, in 0.1 percent of 4096
    logic signed [16:0] err;
    logic        [16:0] err_mag;
    logic        [31:0] err_scaled;
    logic        [31:0] thr_scaled;
    logic               err_over;
    assign err        = $signed({speed_cmd_ramped[15], speed_cmd_ramped}) -
                        $signed({encoder_speed[15], encoder_speed});
    assign err_mag    = err[16] ? 17'(-err) : 17'(err);
    assign err_scaled = 32'(err_mag) * 32'd1000;
    assign thr_scaled = 32'(thr_r) * 32'd4096;
    assign err_over   = err_scaled > thr_scaled;

    // Error duration; any dip below restarts it
    logic speed_trip;
    assign speed_trip = tick && err_over && (err_cnt_r >= trip_r);
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_cnt_r <= 16'h0;
        end else if (!err_over) begin
            err_cnt_r <= 16'h0;
        end else if (tick && err_cnt_r <= trip_r) begin
            err_cnt_r <= err_cnt_r + 16'h1;
        end
    end

    // Counted fault events
    logic fault_evt;
    logic ext_evt;
    assign ext_evt   = fault_sync_r[1] && !fault_prev_r;
    assign fault_evt = (state_r == DFS_RUN) && (speed_trip || ext_evt);

    // Supervisor state machine
    logic auto_fire;
    assign auto_fire = auto_rst_r && (wait_r >= 10'(`DFS_AUTO_RST_TK));
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DFS_RUN: begin
                if (fault_evt && fcount_r >= 3'(`DFS_FAULT_MAX - 1)) begin
                    state_nxt = DFS_LOCKED;
                end else if (fault_evt) begin
                    state_nxt = DFS_TRIPPED;
                end
            end
            DFS_TRIPPED: begin
                if (manual_rst || auto_fire) begin
                    state_nxt = DFS_RUN;
                end
            end
            DFS_LOCKED: begin
                if (manual_rst) begin
                    state_nxt = DFS_RUN;
                end
            end
            default: state_nxt = DFS_RUN;
        endcase
    end

    // State, wait timer, fault count and code
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r       <= DFS_RUN;
            wait_r        <= 10'h0;
            fcount_r      <= 3'h0;
            speed_fault_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            // Timed from the fault event itself
            if (state_r != DFS_TRIPPED) begin
                wait_r <= 10'h0;
            end else if (tick && wait_r < 10'(`DFS_AUTO_RST_TK)) begin
                wait_r <= wait_r + 10'h1;
            end
            // Increment wins over a coincident decrement
            if (fault_evt && fcount_r < 3'(`DFS_FAULT_MAX)) begin
                fcount_r <= fcount_r + 3'h1;
            end else if (leak && fcount_r != 3'h0) begin
                fcount_r <= fcount_r - 3'h1;
            end
            if (fault_evt) begin
                speed_fault_r <= speed_trip;
            end
        end
    end
    assign drive_shutdown = (state_r != DFS_RUN);
    assign fault_code = (state_r == DFS_LOCKED) ? `DFS_F_MAXRST :
                        (state_r == DFS_TRIPPED && speed_fault_r) ?
                        `DFS_F_SPEED : 12'h000;

    // Monitor 1 source select
    logic [15:0] sel1_val;
    assign sel1_val =
        (sel1_r == 4'h0) ? back_emf_estimate :
        (sel1_r == 4'h1) ? speed_cmd_raw :
        (sel1_r == 4'h2) ? speed_cmd_ramped :
        (sel1_r == 4'h3) ? encoder_speed :
        (sel1_r == 4'h4) ? arm_cur_ref :
        (sel1_r == 4'h5) ? arm_cur_meas :
        (sel1_r == 4'h6) ? arm_volt_meas :
        (sel1_r == 4'h7) ? fld_cur_ref : fld_cur_meas;
    assign m0.value = mon0_value;
    assign m0.mult  = mult0_r;
    assign m1.value = sel1_val;
    assign m1.mult  = mult1_r;
    assign mon0_volts = m0.volts;
    assign mon1_volts = m1.volts;

    // Scalers, one per channel
    dfs_mon_scale u_scale0 (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .mon     (m0)
    );
    dfs_mon_scale u_scale1 (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .mon     (m1)
    );

    // Contactor supervision
    dfs_loop_chk u_loop (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .tick       (tick),
        .long_sel   (loop_3s_r),
        .coil_cmd   (coil_cmd),
        .ack_sync   (ack_sync_r[1]),
        .loop_fault (loop_fault)
    );
endmodule

/* File: hw/dfs_cfg.svh */
// Offsets, field positions, reset values and timing counts of the supervisor
`ifndef DFS_CFG_SVH
`define DFS_CFG_SVH
// Register byte addresses
`define DFS_CTRL_ADDR      12'h000
`define DFS_MON_ADDR       12'h004
`define DFS_SPD_ADDR       12'h008
`define DFS_STAT_ADDR      12'h00c
`define DFS_CMD_ADDR       12'h010
// Control field positions
`define DFS_AUTO_RST_BIT   0
`define DFS_LOOP_3S_BIT    1
// Reset values and range limits
`define DFS_SEL1_RST       4'h3
`define DFS_SEL_MAX        4'h8
`define DFS_MULT_RST       16'h00cd
`define DFS_TRIP_RST       16'h01f4
`define DFS_TRIP_MIN       16'h0014
`define DFS_TRIP_MAX       16'h01f4
`define DFS_THR_RST        16'h03e8
`define DFS_THR_MAX        16'h03e8
// Time base: 10 ms tick at 100 MHz
`define DFS_TICK_NS        10000000
`define DFS_CLK_NS         10
`define DFS_TICK_CYC       (`DFS_TICK_NS / `DFS_CLK_NS)
// Times, their tick counts and the fault count limit
`define DFS_AUTO_RST_S     5
`define DFS_AUTO_RST_TK    (`DFS_AUTO_RST_S * 100)
`define DFS_LEAK_MIN       20
`define DFS_LEAK_TK        (`DFS_LEAK_MIN * 60 * 100)
`define DFS_LOOP_SHORT_MS  450
`define DFS_LOOP_SHORT_TK  (`DFS_LOOP_SHORT_MS / 10)
`define DFS_LOOP_LONG_S    3
`define DFS_LOOP_LONG_TK   (`DFS_LOOP_LONG_S * 100)
`define DFS_FAULT_MAX      5
// Fault codes
`define DFS_F_SPEED        12'h19a
`define DFS_F_MAXRST       12'h19b
`endif

/* File: hw/dfs_pkg.sv */
// Types shared by the supervisor modules
package dfs_pkg;
    typedef logic signed [15:0] dfs_sample_type;
    typedef enum logic [1:0] {
        DFS_RUN,
        DFS_TRIPPED,
        DFS_LOCKED
    } dfs_state_type;
endpackage

/* File: hw/dfs_mon_if.sv */
// Monitor scaling request and result between top and scaler
`timescale 1ns/100ps
interface dfs_mon_if;
    logic signed [15:0] value;   // Selected per-unit sample, 1.0 = 4096
    logic        [15:0] mult;    // Multiplier, 1.0 = 256
    logic signed [15:0] volts;   // Output, 10 V = 32767
    modport src  (output value, output mult, input volts);
    modport scal (input value, input mult, output volts);
endinterface

/* File: hw/dfs_mon_scale.sv */
// One monitor channel scaler with saturation
`timescale 1ns/100ps
module dfs_mon_scale
    import dfs_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  sys_rst,
    dfs_mon_if.scal    mon
);
    // Full product; 1 pu times 1.0 gives 4096*256
    logic signed [32:0] prod;
    logic signed [48:0] full;
    logic signed [32:0] lvl;
    logic signed [15:0] sat;
    assign prod = $signed(mon.value) * $signed({1'b0, mon.mult});
    // 10 V per unit: 1 pu at 1.0 (2^20) lands on 32767
    assign full = prod * 49'sd32767;
    assign lvl  = 33'(full >>> 20);
    // Clamp instead of wrap at the rails
    assign sat  = (lvl > 33'sd32767)  ? 16'sh7fff :
                  (lvl < -33'sd32767) ? -16'sh7fff :
                  lvl[15:0];
    // Output register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mon.volts <= 16'sh0000;
        end else begin
            mon.volts <= sat;
        end
    end
endmodule

/* File: hw/dfs_loop_chk.sv */
// Loop contactor acknowledge supervision
`timescale 1ns/100ps
`include "dfs_cfg.svh"
module dfs_loop_chk
    import dfs_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic tick,       // 10 ms enable
    input  wire logic long_sel,   // 1 selects the long window
    input  wire logic coil_cmd,   // Commanded coil state
    input  wire logic ack_sync,   // Synchronised feedback
    output logic      loop_fault  // Mismatch outlasted the window
);
    logic [8:0] cnt_r;            // Mismatch age in ticks
    logic [8:0] limit;
    logic       mismatch;
    assign mismatch = coil_cmd != ack_sync;
    assign limit = long_sel ? 9'(`DFS_LOOP_LONG_TK) :
                              9'(`DFS_LOOP_SHORT_TK);
    // Age the mismatch; match restarts it; fault is sticky level
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r      <= 9'h000;
            loop_fault <= 1'b0;
        end else if (!mismatch) begin
            cnt_r <= 9'h000;
        end else if (tick) begin
            if (cnt_r >= limit) begin
                loop_fault <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 9'h001;
            end
        end
    end
endmodule

/* File: verification/dfs_top_assertions.sv */
// Concurrent checks on the supervisor's top-level ports
`timescale 1ns/100ps
module dfs_top_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        coil_cmd,
    input wire logic        contactor_ack,
    input wire logic [15:0] mon0_volts,
    input wire logic [15:0] mon1_volts,
    input wire logic        drive_shutdown,
    input wire logic [11:0] fault_code,
    input wire logic        loop_fault
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // Address hits one of the five register words
    wire mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};
    // Manual fault reset being written; the only way out of lockout
    wire man_rst = psel && penable && pwrite && paddr == 12'h010 && pwdata[0];
    // Contact disagrees with the coil
    wire mism = coil_cmd != contactor_ack;
    // First cycle of a transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    // Read of a given kind of address
    sequence s_rd_unmapped;
        s_setup ##1 (penable && !pwrite && !mapped);
    endsequence
    sequence s_rd_stat;
        s_setup ##1 (penable && !pwrite && paddr == 12'h00c);
    endsequence
    a_apb_ready: assert property (s_setup |=> pready)
        else $error("access phase not ready");
    a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without error");
    a_mapped_ok: assert property (psel && penable && mapped |-> !pslverr)
        else $error("mapped access flagged as error");
    a_unmapped_zero: assert property (s_rd_unmapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_stat_mirror: assert property (s_rd_stat |-> prdata[15:0] ==
        {$past(fault_code), 2'b00, $past(loop_fault), $past(drive_shutdown)})
        else $error("status word differs from outputs");
    a_code_legal: assert property (fault_code inside {12'h0, 12'h19a,
        12'h19b}) else $error("unknown fault code");
    a_code_stops: assert property (
        fault_code != 12'h0 |-> drive_shutdown)
        else $error("fault code without shutdown");
    a_lock_holds: assert property (fault_code == 12'h19b && !man_rst |=>
        fault_code == 12'h19b) else $error("lockout left");
    a_loop_sticky: assert property (loop_fault |=> loop_fault)
        else $error("loop fault dropped");
    a_loop_cause: assert property ($rose(loop_fault) |-> $past(mism, 5))
        else $error("loop fault without mismatch");
    a_mon_sat: assert property (mon0_volts != 16'h8000 &&
        mon1_volts != 16'h8000) else $error("monitor wrapped");
endmodule

/* File: verification/dfs_contact_model.sv */
// Contactor feedback contact: follows the coil after a set lag
`timescale 1ns/100ps
module dfs_contact_model (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        coil_cmd,
    input  wire logic [15:0] lag,
    input  wire logic        stuck,
    output logic             contactor_ack
);
    logic [15:0] cnt_r; // Cycles the contact has disagreed
    // Contact moves after lag cycles; stuck models a welded contact
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= 16'h0;
            contactor_ack <= 1'b0;
        end else if (coil_cmd == contactor_ack) begin
            cnt_r <= 16'h0;
        end else if (!stuck && cnt_r >= lag) begin
            contactor_ack <= coil_cmd;
        end else begin
            cnt_r <= cnt_r + 16'h1;
        end
    end
endmodule

/* File: verification/dfs_top_tb.sv */
// Self-checking bench for the drive fault supervisor
`timescale 1ns/100ps
module dfs_top_tb;
    logic        sys_clk = 0;
    logic        sys_rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 0, fault_code;
    logic [31:0] pwdata = 0, prdata, q;
    logic [15:0] src [9];               // Monitor 1 sources, code order
    logic [15:0] mon0_value = 0, mon0_volts, mon1_volts;
    logic [15:0] lag = 16'd400;         // Contact travel time in cycles
    logic        ext_fault = 0, coil_cmd = 0, stuck = 0;
    logic        contactor_ack, drive_shutdown, loop_fault;
    int          n_mismatch = 0, n_tests = 0, i;
    // Short tick and a 2000-tick leak period keep the 5 s and 20 min spans affordable
    dfs_top #(.TICK_CYC(10), .LEAK_TK(2000)) i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .back_emf_estimate(src[0]),
        .speed_cmd_raw(src[1]), .speed_cmd_ramped(src[2]),
        .encoder_speed(src[3]), .arm_cur_ref(src[4]),
        .arm_cur_meas(src[5]), .arm_volt_meas(src[6]),
        .fld_cur_ref(src[7]), .fld_cur_meas(src[8]),
        .mon0_value(mon0_value), .ext_fault(ext_fault),
        .coil_cmd(coil_cmd), .contactor_ack(contactor_ack),
        .mon0_volts(mon0_volts), .mon1_volts(mon1_volts),
        .drive_shutdown(drive_shutdown), .fault_code(fault_code),
        .loop_fault(loop_fault));
    dfs_contact_model i_contact (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .coil_cmd(coil_cmd), .lag(lag), .stuck(stuck),
        .contactor_ack(contactor_ack));
    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;
    // Wait n edges, then let their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One APB transfer; read data lands in q
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        check(q, exp);
    endtask
    // Multiplier times 10 V per unit, saturating at full scale
    function automatic logic [15:0] vexp(input logic [15:0] v,
                                         input logic [15:0] m);
        longint p;
        p = longint'($signed(v)) * longint'(m) * 32767 / 1048576;
        if (p > 32767) p = 32767;
        if (p < -32767) p = -32767;
        return p[15:0];
    endfunction
    // Rounding of the last few counts is left free
    task automatic vchk(input logic [15:0] seen, input logic [15:0] v,
                        input logic [15:0] m);
        logic [15:0]        e;
        logic signed [16:0] d;
        e = vexp(v, m);
        d = $signed({seen[15], seen}) - $signed({e[15], e});
        check((d < 5 && d > -5) ? e : seen, e);
    endtask
    // Wait up to n cycles for the shutdown level v
    task automatic wsd(input logic v, input int n);
        repeat (n) if (drive_shutdown !== v) cyc(1);
    endtask
    // Speed error just over 50 %, then removed once tripped
    task automatic trip;
        @(posedge sys_clk);
        src[3] <= 16'h07ff;
        cyc(180);
        check(drive_shutdown, 1'b0);
        wsd(1'b1, 100);
        check(fault_code, 12'h19a);
        @(posedge sys_clk);
        src[3] <= 16'h1000;
    endtask
    // Short pulse of another shutdown fault
    task automatic extf;
        @(posedge sys_clk);
        ext_fault <= 1'b1;
        cyc(4);
        @(posedge sys_clk);
        ext_fault <= 1'b0;
        cyc(6);
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Hang guard, well above the expected 30k cycles
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        for (i = 0; i < 9; i++) src[i] = 16'((i + 1) * 256);
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rchk(12'h000, 32'h0000_0030);
        rchk(12'h004, 32'h00cd_00cd);
        rchk(12'h008, 32'h03e8_01f4);
        rchk(12'h014, 32'h0);
        // Every monitor 1 source through a unit multiplier
        apb(12'h004, 1'b1, 32'h0100_00cd);
        for (i = 0; i < 9; i++) begin
            apb(12'h000, 1'b1, i << 4);
            cyc(3);
            vchk(mon1_volts, src[i], 16'h0100);
        end
        apb(12'h000, 1'b1, 32'h0000_00f0);
        rchk(12'h000, 32'h0000_0080);
        // Channel 0 at 1 pu, then far over and under range
        for (i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            mon0_value <= 16'(48'h9000_7000_1000 >> (i * 16));
            cyc(3);
            vchk(mon0_volts, mon0_value, 16'h00cd);
        end
        apb(12'h008, 1'b1, 32'h0000_0005);
        rchk(12'h008, 32'h0000_0014);
        apb(12'h008, 1'b1, 32'hffff_ffff);
        rchk(12'h008, 32'h03e8_01f4);
        apb(12'h008, 1'b1, 32'h01f4_0014);
        // Error exactly at threshold never trips
        @(posedge sys_clk);
        src[2] <= 16'h1000;
        src[3] <= 16'h0800;
        cyc(400);
        check(drive_shutdown, 1'b0);
        trip();
        cyc(5200);
        check(drive_shutdown, 1'b1);
        apb(12'h010, 1'b1, 32'h1);
        rchk(12'h00c, 32'h0001_0000);
        // Automatic reset 5 s after the fault
        apb(12'h000, 1'b1, 32'h0000_0031);
        trip();
        cyc(4880);
        check(drive_shutdown, 1'b1);
        wsd(1'b0, 240);
        check(drive_shutdown, 1'b0);
        rchk(12'h00c, 32'h0002_0000);
        // Faults three to five; the fifth locks out
        for (i = 3; i < 6; i++) begin
            extf();
            rchk(12'h00c, i == 5 ? 32'h0005_19b1 : (i << 16) + 1);
            if (i < 5) apb(12'h010, 1'b1, 32'h1);
        end
        cyc(5200);
        check(fault_code, 12'h19b);
        // Count leaks by one on the free-running timer
        for (i = 0; i < 400 && q[18:16] == 3'd5; i++) begin
            cyc(50);
            apb(12'h00c, 1'b0, 32'h0);
        end
        check(q[18:16], 3'd4);
        apb(12'h010, 1'b1, 32'h1);
        extf();
        check(fault_code, 12'h19b);
        apb(12'h010, 1'b1, 32'h1);
        // Contact follows within 450 ms, closing then opening
        for (i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            coil_cmd <= !coil_cmd;
            cyc(600);
            check(loop_fault, 1'b0);
        end
        @(posedge sys_clk);
        stuck <= 1'b1;
        coil_cmd <= 1'b1;
        cyc(420);
        check(loop_fault, 1'b0);
        cyc(80);
        check(loop_fault, 1'b1);
        // Mid-run reset, then the 3 s window
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        coil_cmd <= 1'b0;
        stuck <= 1'b0;
        lag <= 16'd2000;
        cyc(3);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        rchk(12'h00c, 32'h0);
        apb(12'h000, 1'b1, 32'h0000_0032);
        @(posedge sys_clk);
        coil_cmd <= 1'b1;
        cyc(2200);
        check(loop_fault, 1'b0);
        @(posedge sys_clk);
        stuck <= 1'b1;
        coil_cmd <= 1'b0;
        cyc(2950);
        check(loop_fault, 1'b0);
        cyc(150);
        check(loop_fault, 1'b1);
        print_verdict();
    end
endmodule
bind dfs_top dfs_top_chk i_chk (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .coil_cmd(coil_cmd), .contactor_ack(contactor_ack),
    .mon0_volts(mon0_volts), .mon1_volts(mon1_volts),
    .drive_shutdown(drive_shutdown), .fault_code(fault_code),
    .loop_fault(loop_fault));
